// *** verilog/ebw_consts.svh ***
// address map, config field positions and fixed values of the external bus window controller
`ifndef EBW_CONSTS_SVH
`define EBW_CONSTS_SVH
`define EBW_EXT0_HI   24'h00_7FFF
`define EBW_EXT1_LO   24'h01_0000
`define EBW_EXT1_HI   24'h1F_FFFF
`define EBW_CAN_LO    24'h20_0000
`define EBW_CAN_HI    24'h20_3FFF
`define EBW_SER_LO    24'h20_4000
`define EBW_SER_HI    24'h20_57FF
`define EBW_IO_LO     24'h20_5800
`define EBW_IO_HI     24'h3F_FFFF
`define EBW_EXT2_LO   24'h40_0000
`define EBW_EXT2_HI   24'hBF_FFFF
`define EBW_ONE       24'h00_0001
`define EBW_MAX_LINES 5'h17
`define EBW_WIN_LSB   12
`define EBW_WIN_MASK  12'hFFF
`define EBW_TCFG_W    6
`define EBW_T_WAIT    3:0
`define EBW_T_RDY_EN  4
`define EBW_T_RDY_POL 5
`define EBW_FCFG_W    3
`define EBW_F_BW16    0
`define EBW_F_MUX     1
`define EBW_F_CS_EN   2
`define EBW_CS_NONE   4'hF
`define EBW_CS_LAST   3'h3
`define EBW_LO_BYTE   8'h00
`endif

// *** verilog/ebw_pkg.sv ***
// state types of the external bus window controller
package ebw_pkg;
    typedef enum logic [1:0] {
        SYS_IDLE = 2'b00,
        SYS_EXT  = 2'b01,
        SYS_LPB  = 2'b11
    } ebw_sys_e;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ADDR = 2'b01,
        BUS_STRB = 2'b11,
        BUS_HOLD = 2'b10
    } ebw_bus_e;
endpackage : ebw_pkg

// *** verilog/ebw_dec_if.sv ***
// carrier between the request side and the window decoder
interface ebw_dec_if;
    logic [23:0] addr;
    logic [2:0]  set;
    modport dec (input addr, output set);
    modport usr (output addr, input set);
endinterface : ebw_dec_if

// *** verilog/ebw_sync.sv ***
// two flip-flop level synchroniser
module ebw_sync #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta <= '0;
            o_q  <= '0;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end
endmodule : ebw_sync

// *** verilog/ebw_win_dec.sv ***
// four address windows, highest numbered window wins
`include "ebw_consts.svh"
module ebw_win_dec (
    ebw_dec_if.dec           d,
    input  wire logic [3:0]  i_win_en,
    input  wire logic [47:0] i_win_base,
    input  wire logic [15:0] i_win_size
);
    logic [3:0] hit;

    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_win
            logic [11:0] mask;
            assign mask   = `EBW_WIN_MASK << i_win_size[4*k +: 4];
            assign hit[k] = i_win_en[k] &&
                            (((d.addr[23:`EBW_WIN_LSB] ^ i_win_base[12*k +: 12]) & mask) == 12'h000);
        end
    endgenerate

    always_comb begin
        d.set = 3'd0;
        if (hit[0]) begin
            d.set = 3'd1;
        end
        if (hit[1]) begin
            d.set = 3'd2;
        end
        if (hit[2]) begin
            d.set = 3'd3;
        end
        if (hit[3]) begin
            d.set = 3'd4;
        end
    end
endmodule : ebw_win_dec

// *** verilog/ebw_ctrl.sv ***
// external bus window controller: request decode, local bus steering and external bus engine
`include "ebw_consts.svh"
module ebw_ctrl (
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_link_clk,
    input  wire logic        i_req_valid,
    input  wire logic [23:0] i_req_addr,
    input  wire logic        i_req_write,
    input  wire logic        i_req_byte,
    input  wire logic [15:0] i_req_wdata,
    output logic             o_req_ready,
    output logic             o_rsp_valid,
    output logic [15:0]      o_rsp_rdata,
    output logic             o_rsp_err,
    input  wire logic        i_ext_mode,
    input  wire logic [4:0]  i_addr_lines,
    input  wire logic [3:0]  i_win_en,
    input  wire logic [47:0] i_win_base,
    input  wire logic [15:0] i_win_size,
    input  wire logic [29:0] i_tcfg,
    input  wire logic [14:0] i_fcfg,
    output logic             o_lpb_valid,
    output logic             o_lpb_can_sel,
    output logic             o_lpb_ser_sel,
    output logic [23:0]      o_lpb_addr,
    output logic             o_lpb_write,
    output logic             o_lpb_byte,
    output logic [15:0]      o_lpb_wdata,
    input  wire logic        i_lpb_done,
    input  wire logic [15:0] i_lpb_rdata,
    output logic             o_bus_ref_clock_out,
    output logic [15:0]      o_ad_out,
    output logic             o_ad_oe,
    input  wire logic [15:0] i_ad_in,
    output logic [15:0]      o_addr_lo,
    output logic [15:0]      o_addr_lo_oe,
    output logic [7:0]       o_seg_out,
    output logic [7:0]       o_seg_oe,
    output logic             o_ale,
    output logic             o_rd_n,
    output logic             o_wr_n,
    output logic             o_bhe_n,
    output logic [3:0]       o_cs_n,
    input  wire logic        i_ready
);
    ebw_pkg::ebw_sys_e sys_st;
    ebw_pkg::ebw_bus_e bus_st;

    ebw_dec_if dif ();
    assign dif.addr = i_req_addr;

    ebw_win_dec u_dec (
        .d          (dif.dec),
        .i_win_en   (i_win_en),
        .i_win_base (i_win_base),
        .i_win_size (i_win_size)
    );

    // request decode
    logic        accept;
    logic        in_ext;
    logic        in_io;
    logic        in_can;
    logic        in_ser;
    logic        split;
    logic [5:0]  tsel;
    logic [2:0]  fsel;
    logic [3:0]  cs_sel;
    logic [4:0]  lines_eff;
    logic [23:0] lmask;

    assign accept = i_req_valid && o_req_ready;
    assign in_ext = (i_req_addr <= `EBW_EXT0_HI) ||
                    (i_req_addr >= `EBW_EXT1_LO && i_req_addr <= `EBW_EXT1_HI) ||
                    (i_req_addr >= `EBW_EXT2_LO && i_req_addr <= `EBW_EXT2_HI);
    assign in_io  = i_req_addr >= `EBW_IO_LO && i_req_addr <= `EBW_IO_HI;
    assign in_can = i_req_addr >= `EBW_CAN_LO && i_req_addr <= `EBW_CAN_HI;
    assign in_ser = i_req_addr >= `EBW_SER_LO && i_req_addr <= `EBW_SER_HI;
    assign tsel   = i_tcfg[dif.set*`EBW_TCFG_W +: `EBW_TCFG_W];
    assign fsel   = i_fcfg[dif.set*`EBW_FCFG_W +: `EBW_FCFG_W];
    assign split  = !i_req_byte && (!fsel[`EBW_F_BW16] || i_req_addr[0]);
    assign lines_eff = (i_addr_lines > `EBW_MAX_LINES) ? `EBW_MAX_LINES : i_addr_lines;

    genvar b;
    generate
        for (b = 0; b < 24; b++) begin : g_lines
            assign lmask[b] = (5'(b) < lines_eff);
        end
    endgenerate

    always_comb begin
        cs_sel = `EBW_CS_NONE;
        if (fsel[`EBW_F_CS_EN] && dif.set <= `EBW_CS_LAST) begin
            cs_sel[dif.set[1:0]] = 1'b0;
        end
    end

    // words handed to the link side, stable while a request is open
    logic [23:0] x_addr;
    logic [15:0] x_wdata;
    logic        x_write;
    logic        x_byte;
    logic        x_split;
    logic [3:0]  x_waits;
    logic        x_rdy_en;
    logic        x_rdy_pol;
    logic        x_bw16;
    logic        x_mux;
    logic [3:0]  x_cs_n;
    logic [23:0] x_amask;
    logic        x_req_tgl;
    logic        done_s;
    logic        done_seen;
    logic        posted;
    logic        l_done_tgl;
    logic [15:0] l_rdata;

    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            x_addr    <= '0;
            x_wdata   <= '0;
            x_write   <= 1'b0;
            x_byte    <= 1'b0;
            x_split   <= 1'b0;
            x_waits   <= '0;
            x_rdy_en  <= 1'b0;
            x_rdy_pol <= 1'b0;
            x_bw16    <= 1'b0;
            x_mux     <= 1'b0;
            x_cs_n    <= `EBW_CS_NONE;
            x_amask   <= '0;
            x_req_tgl <= 1'b0;
        end else if (accept && i_ext_mode && (in_ext || in_io)) begin
            x_addr    <= i_req_addr & lmask;
            x_wdata   <= i_req_wdata;
            x_write   <= i_req_write;
            x_byte    <= i_req_byte;
            x_split   <= split;
            x_waits   <= tsel[`EBW_T_WAIT];
            x_rdy_en  <= tsel[`EBW_T_RDY_EN];
            x_rdy_pol <= tsel[`EBW_T_RDY_POL];
            x_bw16    <= fsel[`EBW_F_BW16];
            x_mux     <= fsel[`EBW_F_MUX];
            x_cs_n    <= cs_sel;
            x_amask   <= lmask;
            x_req_tgl <= ~x_req_tgl;
        end
    end

    ebw_sync #(.W(1)) u_done_sync (
        .i_clk (i_mclk),
        .i_rst (i_sys_rst),
        .i_d   (l_done_tgl),
        .o_q   (done_s)
    );

    // request side sequencer
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sys_st        <= ebw_pkg::SYS_IDLE;
            o_req_ready   <= 1'b1;
            o_rsp_valid   <= 1'b0;
            o_rsp_rdata   <= '0;
            o_rsp_err     <= 1'b0;
            o_lpb_valid   <= 1'b0;
            o_lpb_can_sel <= 1'b0;
            o_lpb_ser_sel <= 1'b0;
            o_lpb_addr    <= '0;
            o_lpb_write   <= 1'b0;
            o_lpb_byte    <= 1'b0;
            o_lpb_wdata   <= '0;
            done_seen     <= 1'b0;
            posted        <= 1'b0;
        end else begin
            o_rsp_valid <= 1'b0;
            case (sys_st)
                ebw_pkg::SYS_IDLE: begin
                    if (accept) begin
                        o_rsp_rdata <= '0;
                        o_rsp_err   <= 1'b0;
                        if (in_ext || in_io) begin
                            if (!i_ext_mode) begin
                                o_rsp_valid <= 1'b1;
                                o_rsp_err   <= 1'b1;
                            end else begin
                                posted      <= i_req_write && !in_io;
                                o_rsp_valid <= i_req_write && !in_io;
                                o_req_ready <= 1'b0;
                                sys_st      <= ebw_pkg::SYS_EXT;
                            end
                        end else if (in_can || in_ser) begin
                            o_lpb_valid   <= 1'b1;
                            o_lpb_can_sel <= in_can;
                            o_lpb_ser_sel <= in_ser;
                            o_lpb_addr    <= i_req_addr;
                            o_lpb_write   <= i_req_write;
                            o_lpb_byte    <= i_req_byte;
                            o_lpb_wdata   <= i_req_wdata;
                            o_req_ready   <= 1'b0;
                            sys_st        <= ebw_pkg::SYS_LPB;
                        end else begin
                            o_rsp_valid <= 1'b1;
                            o_rsp_err   <= 1'b1;
                        end
                    end
                end
                ebw_pkg::SYS_EXT: begin
                    if (done_s != done_seen) begin
                        done_seen   <= done_s;
                        o_rsp_valid <= !posted;
                        o_rsp_rdata <= x_write ? 16'h0000 : l_rdata;
                        o_req_ready <= 1'b1;
                        sys_st      <= ebw_pkg::SYS_IDLE;
                    end
                end
                ebw_pkg::SYS_LPB: begin
                    if (i_lpb_done) begin
                        o_lpb_valid   <= 1'b0;
                        o_lpb_can_sel <= 1'b0;
                        o_lpb_ser_sel <= 1'b0;
                        o_rsp_valid   <= 1'b1;
                        o_rsp_rdata   <= o_lpb_write ? 16'h0000 : i_lpb_rdata;
                        o_req_ready   <= 1'b1;
                        sys_st        <= ebw_pkg::SYS_IDLE;
                    end
                end
                default: begin
                    sys_st <= ebw_pkg::SYS_IDLE;
                end
            endcase
        end
    end

    // link domain reset release
    logic lrst_m;
    logic lrst;

    always_ff @(posedge i_link_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            lrst_m <= 1'b1;
            lrst   <= 1'b1;
        end else begin
            lrst_m <= 1'b0;
            lrst   <= lrst_m;
        end
    end

    logic        req_s;
    logic        req_seen;
    logic [16:0] pin_s;
    logic        l_ph2;
    logic [3:0]  l_cnt;
    logic [23:0] l_na;
    logic [7:0]  l_bsel;
    logic [7:0]  l_dbyte;
    logic        l_pbyte;
    logic        l_go;

    ebw_sync #(.W(1)) u_req_sync (
        .i_clk (i_link_clk),
        .i_rst (lrst),
        .i_d   (x_req_tgl),
        .o_q   (req_s)
    );

    ebw_sync #(.W(17)) u_pin_sync (
        .i_clk (i_link_clk),
        .i_rst (lrst),
        .i_d   ({i_ready, i_ad_in}),
        .o_q   (pin_s)
    );

    always_ff @(posedge i_link_clk or posedge lrst) begin
        if (lrst) begin
            o_bus_ref_clock_out <= 1'b0;
        end else begin
            o_bus_ref_clock_out <= ~o_bus_ref_clock_out;
        end
    end

    assign l_go    = (bus_st == ebw_pkg::BUS_HOLD) && x_split && !l_ph2;
    assign l_na    = l_go ? ((x_addr + `EBW_ONE) & x_amask) : x_addr;
    assign l_pbyte = x_byte || x_split;
    assign l_dbyte = l_ph2 ? x_wdata[15:8] : x_wdata[7:0];
    assign l_bsel  = (x_bw16 && o_addr_lo[0]) ? pin_s[15:8] : pin_s[7:0];

    // external bus engine, steps only as the reference clock rises
    always_ff @(posedge i_link_clk or posedge lrst) begin
        if (lrst) begin
            bus_st       <= ebw_pkg::BUS_IDLE;
            req_seen     <= 1'b0;
            l_done_tgl   <= 1'b0;
            l_ph2        <= 1'b0;
            l_cnt        <= '0;
            l_rdata      <= '0;
            o_ad_out     <= '0;
            o_ad_oe      <= 1'b0;
            o_addr_lo    <= '0;
            o_addr_lo_oe <= '0;
            o_seg_out    <= '0;
            o_seg_oe     <= '0;
            o_ale        <= 1'b0;
            o_rd_n       <= 1'b1;
            o_wr_n       <= 1'b1;
            o_bhe_n      <= 1'b1;
            o_cs_n       <= `EBW_CS_NONE;
        end else if (!o_bus_ref_clock_out) begin
            case (bus_st)
                ebw_pkg::BUS_IDLE, ebw_pkg::BUS_HOLD: begin
                    if ((bus_st == ebw_pkg::BUS_IDLE && req_s != req_seen) || l_go) begin
                        req_seen     <= req_s;
                        l_ph2        <= l_go;
                        o_cs_n       <= x_cs_n;
                        o_ale        <= 1'b1;
                        o_ad_out     <= l_na[15:0];
                        o_ad_oe      <= x_mux;
                        o_addr_lo    <= l_na[15:0];
                        o_addr_lo_oe <= x_mux ? 16'h0000 : x_amask[15:0];
                        o_seg_out    <= l_na[23:16];
                        o_seg_oe     <= x_amask[23:16];
                        o_bhe_n      <= !(x_bw16 && (!l_pbyte || l_na[0]));
                        bus_st       <= ebw_pkg::BUS_ADDR;
                    end else if (bus_st == ebw_pkg::BUS_HOLD) begin
                        l_done_tgl   <= ~l_done_tgl;
                        o_cs_n       <= `EBW_CS_NONE;
                        o_ad_oe      <= 1'b0;
                        o_addr_lo_oe <= '0;
                        o_bhe_n      <= 1'b1;
                        bus_st       <= ebw_pkg::BUS_IDLE;
                    end
                end
                ebw_pkg::BUS_ADDR: begin
                    o_ale    <= 1'b0;
                    o_rd_n   <= x_write;
                    o_wr_n   <= !x_write;
                    o_ad_oe  <= x_write;
                    o_ad_out <= l_pbyte ? {l_dbyte, l_dbyte} : x_wdata;
                    l_cnt    <= x_waits;
                    bus_st   <= ebw_pkg::BUS_STRB;
                end
                ebw_pkg::BUS_STRB: begin
                    if (l_cnt != 4'h0) begin
                        l_cnt <= l_cnt - 4'h1;
                    end else if (!x_rdy_en || pin_s[16] == x_rdy_pol) begin
                        o_rd_n <= 1'b1;
                        o_wr_n <= 1'b1;
                        if (!l_pbyte) begin
                            l_rdata <= pin_s[15:0];
                        end else if (l_ph2) begin
                            l_rdata[15:8] <= l_bsel;
                        end else begin
                            l_rdata <= {`EBW_LO_BYTE, l_bsel};
                        end
                        bus_st <= ebw_pkg::BUS_HOLD;
                    end
                end
                default: begin
                    bus_st <= ebw_pkg::BUS_IDLE;
                end
            endcase
        end
    end
endmodule : ebw_ctrl

// *** sim/ebw_mem_model.sv ***
// external memory model on the multiplexed address/data bus
module ebw_mem_model (
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_bus8,
    input  wire logic        i_pol,
    input  wire logic [7:0]  i_dly,
    input  wire logic        i_ale,
    input  wire logic [15:0] i_ad,
    input  wire logic [7:0]  i_seg,
    input  wire logic [7:0]  i_seg_oe,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic        i_bhe_n,
    output logic      [15:0] o_ad,
    output logic             o_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [0:511];
    logic [23:0] a;
    logic [15:0] last;
    logic [15:0] rd;
    logic [7:0]  cnt;
    initial begin
        for (int i = 0; i < 512; i++) mem[i] = i[7:0];
    end
    assign rd = i_bus8 ? {~mem[a[8:0]], mem[a[8:0]]} : {mem[{a[8:1], 1'b1}], mem[{a[8:1], 1'b0}]};
    assign o_ad = !i_rd_n ? rd : ~last;
    assign o_ready = (cnt >= i_dly) ? i_pol : ~i_pol;
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt <= 8'h00;
            last <= 16'h0000;
        end else begin
            if (i_ale) a <= {i_seg & i_seg_oe, i_ad};
            cnt <= (!i_rd_n || !i_wr_n) ? cnt + 8'h01 : 8'h00;
            if (!i_rd_n) last <= rd;
            if (!i_wr_n && (i_bus8 || !a[0])) mem[a[8:0]] <= i_ad[7:0];
            if (!i_wr_n && !i_bus8 && !i_bhe_n) mem[{a[8:1], 1'b1}] <= i_ad[15:8];
        end
    end
endmodule : ebw_mem_model

// *** sim/ebw_ctrl_props.sv ***
// concurrent checks on the ports of the bus window controller
`include "ebw_consts.svh"
module ebw_ctrl_props (
    input wire logic        i_mclk,
    input wire logic        i_sys_rst,
    input wire logic        i_link_clk,
    input wire logic        i_req_valid,
    input wire logic [23:0] i_req_addr,
    input wire logic        i_req_write,
    input wire logic        i_ext_mode,
    input wire logic [4:0]  i_addr_lines,
    input wire logic        o_req_ready,
    input wire logic        o_rsp_valid,
    input wire logic        o_rsp_err,
    input wire logic        o_lpb_valid,
    input wire logic        o_lpb_can_sel,
    input wire logic        o_lpb_ser_sel,
    input wire logic [23:0] o_lpb_addr,
    input wire logic        o_bus_ref_clock_out,
    input wire logic        o_ad_oe,
    input wire logic        o_ale,
    input wire logic        o_rd_n,
    input wire logic        o_wr_n,
    input wire logic [7:0]  o_seg_oe,
    input wire logic [3:0]  o_cs_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] a;
    logic        tk, ext_a, io_a, lpb_a;
    logic [4:0]  nl;
    logic [7:0]  seg_m;
    assign a = i_req_addr;
    assign tk = i_req_valid & o_req_ready;
    assign ext_a = a <= `EBW_EXT0_HI || (a >= `EBW_EXT1_LO && a <= `EBW_EXT1_HI) || (a >= `EBW_EXT2_LO && a <= `EBW_EXT2_HI);
    assign lpb_a = a >= `EBW_CAN_LO && a <= `EBW_SER_HI;
    assign io_a = a >= `EBW_IO_LO && a <= `EBW_IO_HI;
    assign nl = (i_addr_lines > 5'd23) ? 5'd23 : i_addr_lines;
    assign seg_m = (nl > 5'd16) ? 8'((9'h001 << (nl - 5'd16)) - 9'h001) : 8'h00;
    property p_sc_refuse;
        @(posedge i_mclk) disable iff (i_sys_rst) tk && !i_ext_mode && ext_a |=> o_rsp_valid && o_rsp_err;
    endproperty
    a_sc_refuse: assert property (p_sc_refuse) else $error("single-chip access not refused");
    property p_unmapped;
        @(posedge i_mclk) disable iff (i_sys_rst) tk && !ext_a && !io_a && !lpb_a |=> o_rsp_valid && o_rsp_err;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_lpb_route;
        @(posedge i_mclk) disable iff (i_sys_rst) tk && lpb_a |=> o_lpb_valid && o_lpb_addr == $past(a)
            && o_lpb_ser_sel == ($past(a) >= `EBW_SER_LO) && o_lpb_can_sel != o_lpb_ser_sel;
    endproperty
    a_lpb_route: assert property (p_lpb_route) else $error("local bus target wrong");
    property p_post;
        @(posedge i_mclk) disable iff (i_sys_rst) tk && i_ext_mode && i_req_write && (ext_a || io_a)
            |=> o_rsp_valid == $past(ext_a) && !o_req_ready;
    endproperty
    a_post: assert property (p_post) else $error("io write posted or memory write not posted");
    property p_ref_edge;
        @(posedge i_link_clk) disable iff (i_sys_rst) $changed({o_rd_n, o_wr_n, o_ale, o_cs_n}) |-> $rose(o_bus_ref_clock_out);
    endproperty
    a_ref_edge: assert property (p_ref_edge) else $error("bus change off reference rise");
    property p_cs_one;
        @(posedge i_link_clk) disable iff (i_sys_rst) $countones(~o_cs_n) <= 1;
    endproperty
    a_cs_one: assert property (p_cs_one) else $error("two chip selects active");
    property p_rd_release;
        @(posedge i_link_clk) disable iff (i_sys_rst) !o_rd_n |-> !o_ad_oe && !o_ale && o_wr_n;
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("bus driven during read strobe");
    property p_seg;
        @(posedge i_link_clk) disable iff (i_sys_rst) $rose(o_ale) |-> (o_seg_oe & ~seg_m) == 8'h00;
    endproperty
    a_seg: assert property (p_seg) else $error("segment line above width driven");
    c_lpb: cover property (@(posedge i_mclk) o_lpb_valid && o_lpb_ser_sel);
    c_rd: cover property (@(posedge i_link_clk) $fell(o_rd_n));
    c_wr: cover property (@(posedge i_link_clk) $fell(o_wr_n));
endmodule : ebw_ctrl_props
bind ebw_ctrl ebw_ctrl_props u_props (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_link_clk(i_link_clk),
    .i_req_valid(i_req_valid), .i_req_addr(i_req_addr), .i_req_write(i_req_write), .i_ext_mode(i_ext_mode),
    .i_addr_lines(i_addr_lines), .o_req_ready(o_req_ready), .o_rsp_valid(o_rsp_valid), .o_rsp_err(o_rsp_err),
    .o_lpb_valid(o_lpb_valid), .o_lpb_can_sel(o_lpb_can_sel), .o_lpb_ser_sel(o_lpb_ser_sel), .o_lpb_addr(o_lpb_addr),
    .o_bus_ref_clock_out(o_bus_ref_clock_out), .o_ad_oe(o_ad_oe), .o_ale(o_ale), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n),
    .o_seg_oe(o_seg_oe), .o_cs_n(o_cs_n));

// *** sim/ebw_ctrl_tb_top.sv ***
// testbench of the bus window controller
module ebw_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, lclk = 0, rst = 1, valid = 0, wr = 0, byt = 0, ext = 0, done = 0, m_bus8 = 0, m_pol = 1;
    logic rsp, err, lval, ale, rd_n, wr_n, bhe_n, rdy, rref, m_rdy;
    logic [23:0] addr = 0, laddr;
    logic [15:0] wdata = 0, ldata = 0, rdata, ad_o, ad_i, q;
    logic [7:0]  seg, seg_oe, m_dly = 0;
    logic [3:0]  cs_n, cs_acc;
    logic [4:0]  lines = 5'd24;
    logic        e;
    int          err_count = 0, n_checks = 0, cyc, t;
    logic [23:0] wa [6] = '{24'h00_0100, 24'h01_0000, 24'h01_1000, 24'h01_2000, 24'h01_3000, 24'h40_0200};
    logic [3:0]  csx [6] = '{4'hE, 4'hB, 4'hD, 4'h7, 4'hF, 4'hE};
    logic [23:0] lp [4] = '{24'h20_0000, 24'h20_3FFF, 24'h20_4000, 24'h20_57FF};
    initial forever #10 mclk = ~mclk;
    initial begin
        #7;
        forever #24 lclk = ~lclk;
    end
    ebw_ctrl dut (.i_mclk(mclk), .i_sys_rst(rst), .i_link_clk(lclk), .i_req_valid(valid), .i_req_addr(addr),
        .i_req_write(wr), .i_req_byte(byt), .i_req_wdata(wdata), .o_req_ready(rdy), .o_rsp_valid(rsp),
        .o_rsp_rdata(rdata), .o_rsp_err(err), .i_ext_mode(ext), .i_addr_lines(lines), .i_win_en(4'hF),
        .i_win_base({12'h013, 12'h012, 12'h010, 12'h010}), .i_win_size({4'h0, 4'h1, 4'h0, 4'h1}),
        .i_tcfg({6'h32, 6'h02, 6'h02, 6'h12, 6'h02}), .i_fcfg({3'b111, 3'b110, 3'b111, 3'b111, 3'b111}),
        .o_lpb_valid(lval), .o_lpb_can_sel(), .o_lpb_ser_sel(), .o_lpb_addr(laddr), .o_lpb_write(),
        .o_lpb_byte(), .o_lpb_wdata(), .i_lpb_done(done), .i_lpb_rdata(ldata), .o_bus_ref_clock_out(rref),
        .o_ad_out(ad_o), .o_ad_oe(), .i_ad_in(ad_i), .o_addr_lo(), .o_addr_lo_oe(), .o_seg_out(seg),
        .o_seg_oe(seg_oe), .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_bhe_n(bhe_n), .o_cs_n(cs_n), .i_ready(m_rdy));
    ebw_mem_model u_mem (.i_clk(lclk), .i_rst(rst), .i_bus8(m_bus8), .i_pol(m_pol), .i_dly(m_dly), .i_ale(ale),
        .i_ad(ad_o), .i_seg(seg), .i_seg_oe(seg_oe), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_bhe_n(bhe_n),
        .o_ad(ad_i), .o_ready(m_rdy));
    // local bus peripheral answers one cycle later
    always @(posedge mclk) begin
        done <= lval && !done;
        ldata <= ~laddr[15:0];
    end
    always @(posedge lclk) cs_acc = cs_acc & cs_n;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        if (err_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic acc(input logic [23:0] a, input logic w, input logic b, input logic [15:0] d);
        int n;
        @(posedge mclk);
        #1;
        {valid, addr, wr, byt, wdata} = {1'b1, a, w, b, d};
        cs_acc = 4'hF;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (rdy !== 1'b1 && n < 3000);
        if (rdy !== 1'b1) err_count++;
        #1;
        valid = 0;
        n = 0;
        while (rsp !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (rsp !== 1'b1) err_count++;
        q = rdata;
        e = err;
        cyc = n;
    endtask : acc
    initial begin
        #500_000;
        err_count++;
        conclude();
    end
    initial begin
        repeat (20) @(posedge mclk);
        #1 rst = 0;
        acc(24'h00_1000, 0, 0, 16'h0000);
        chk(e, 1);
        ext = 1;
        acc(24'h00_A000, 0, 0, 16'h0000);
        chk(e, 1);
        for (int i = 0; i < 4; i++) begin
            acc(lp[i], 0, 0, 16'h0000);
            chk({e, q}, {1'b0, ~lp[i][15:0]});
        end
        acc(24'h20_5800, 1, 0, 16'h1234);
        chk(e, 0);
        chk(cyc > 2, 1);
        for (int i = 0; i < 6; i++) begin
            m_pol = (i != 2);
            m_bus8 = (i == 3);
            acc(wa[i], 1, 0, {8'h5A, 8'(i)});
            acc(wa[i], 0, 0, 16'h0000);
            chk({e, q}, {9'h05A, 8'(i)});
            chk(cs_acc, csx[i]);
        end
        m_bus8 = 0;
        acc(24'h40_0201, 1, 1, 16'h0033);
        acc(24'h40_0200, 0, 0, 16'h0000);
        chk(q, 16'h3305);
        acc(24'h40_0201, 0, 1, 16'h0000);
        chk(q, 16'h0033);
        m_pol = 0;
        acc(24'h01_1000, 0, 0, 16'h0000);
        t = cyc;
        m_dly = 8'd12;
        acc(24'h01_1000, 0, 0, 16'h0000);
        chk(q, 16'h3305);
        chk(cyc > t + 5, 1);
        {m_dly, m_pol, lines} = {8'd0, 1'b1, 5'd20};
        acc(24'h40_0200, 0, 0, 16'h0000);
        chk(q, 16'h3305);
        chk(seg_oe, 8'h0F);
        conclude();
    end
endmodule : ebw_ctrl_tb_top
